// file: rtl/scc_spindle_ctrl.sv
// Spindle commutation controller top: mode control, PWM, commutation.
// Assumes torque inputs as unsigned millivolt codes and a 100 MHz clk.
//
// How it works
// - Run/stop acts only while the carrier oscillator runs; high drives.
// - Run/stop low: all high sides on, all low sides off.
// - Hall state picks the excited phase pair from a six-step table.
// - Low side carries PWM; PWM off recirculates through high side.
// - Duty rises linearly with reference minus command for forward drive.
// - Deadband of 50 mV; full duty at 0.75 V beyond it.
// - Brake select low and command at or above reference: short brake.
// - Brake select high and command above reference: reverse drive.
// - In reverse brake, backward rotation stops all drive.
// - Speed pulse output follows Hall transitions.
// - Speed select low: single Hall phase; high: three-phase combined.
// - Standby input low: outputs high impedance; high: operation.
// - Carrier oscillator halts in standby.
// - Drive stays off for a start-up interval after standby ends.
// - Triangle carrier near 75 kHz.
`timescale 1ns/100ps
`include "scc_params.svh"

module scc_spindle_ctrl
  import scc_pkg::*;
#(
  parameter int CODE_W = 12,
  parameter int STARTUP_CYC = `SCC_STARTUP_CYC,
  parameter int DEAD_CYC = `SCC_DEAD_CYC
) (
  input wire logic clk, // System clock, 100 MHz
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic run_stop_in, // High runs, low brakes
  input wire logic standby_n_in, // Low enters standby
  input wire logic brake_style_select, // High selects reverse brake
  input wire logic speed_pulse_select, // High selects three-phase pulse
  input wire logic hall_a_pos, // Hall comparator a
  input wire logic hall_b_pos, // Hall comparator b
  input wire logic hall_c_pos, // Hall comparator c
  input wire logic [CODE_W-1:0] torque_reference, // Reference, mV
  input wire logic [CODE_W-1:0] torque_command, // Command, mV
  output logic [2:0] phase_out_hs, // High-side on, bit 0 is U
  output logic [2:0] phase_out_ls, // Low-side on, bit 0 is U
  output logic phase_out_en, // Low leaves windings floating
  output logic speed_pulse_out // Speed pulse
);

  localparam int TRI_W = 11;
  localparam int MAG_W = CODE_W + 1;
  localparam int PROD_W = MAG_W + TRI_W;
  localparam int SU_W = $clog2(STARTUP_CYC + 1);
  localparam logic [TRI_W-1:0] TRI_PEAK = TRI_W'(`SCC_TRI_PEAK);
  localparam logic [TRI_W-1:0] DUTY_FULL = TRI_W'(`SCC_TRI_PEAK + 1);
  localparam logic [MAG_W-1:0] DB_MV = MAG_W'(`SCC_DEADBAND_MV);
  localparam logic [MAG_W-1:0] FULL_MV = MAG_W'(`SCC_FULL_DUTY_MV);

  generate
    if (CODE_W < 11 || STARTUP_CYC < 1) begin : g_bad
      $error("scc_spindle_ctrl: CODE_W or STARTUP_CYC out of range");
    end
  endgenerate

  scc_core_if cif ();

  scc_hall_sync u_hall (
    .clk(clk),
    .resetn(resetn),
    .hall_a_pos(hall_a_pos),
    .hall_b_pos(hall_b_pos),
    .hall_c_pos(hall_c_pos),
    .cif(cif)
  );

  scc_dead_time #(.DEAD_CYC(DEAD_CYC)) u_dead (
    .clk(clk),
    .resetn(resetn),
    .cif(cif)
  );

  scc_mode_t mode_q;
  scc_mode_t mode_d;
  logic [TRI_W-1:0] tri_q;
  logic tri_up_q;
  logic [TRI_W-1:0] duty_q;
  logic pwm_on_q;
  logic [SU_W-1:0] startup_q;
  logic rev_halt_q;
  logic out_en_q;
  logic speed_q;

  // Torque difference, magnitude and direction requests
  wire signed [MAG_W:0] diff = $signed({2'b00, torque_reference}) -
                               $signed({2'b00, torque_command});
  wire [MAG_W-1:0] mag = diff[MAG_W] ? MAG_W'(-diff) : MAG_W'(diff);
  wire fwd_req = !diff[MAG_W] && (diff != '0);
  wire rev_req = brake_style_select && diff[MAG_W];

  // Linear duty beyond the deadband, clipped at full
  wire over_db = mag > DB_MV;
  wire [MAG_W-1:0] excess = MAG_W'(mag - DB_MV);
  wire [PROD_W-1:0] prod = PROD_W'(excess) * PROD_W'(TRI_PEAK);
  wire [TRI_W-1:0] duty_lin = TRI_W'(prod / PROD_W'(FULL_MV));
  wire [TRI_W-1:0] duty_calc = !over_db ? '0 :
                               (excess >= FULL_MV) ? DUTY_FULL :
                               duty_lin;

  // Commutation step from Hall state; reverse drive swaps the pair
  wire [2:0] step = scc_step_of(cif.hall_state);
  wire hall_bad = (step == `SCC_STEP_NONE);
  logic [1:0] src_ph;
  logic [1:0] snk_ph;
  always_comb begin
    src_ph = `SCC_PH_NONE;
    snk_ph = `SCC_PH_NONE;
    case (step)
      3'h0: begin src_ph = `SCC_PH_W; snk_ph = `SCC_PH_V; end
      3'h1: begin src_ph = `SCC_PH_W; snk_ph = `SCC_PH_U; end
      3'h2: begin src_ph = `SCC_PH_V; snk_ph = `SCC_PH_U; end
      3'h3: begin src_ph = `SCC_PH_V; snk_ph = `SCC_PH_W; end
      3'h4: begin src_ph = `SCC_PH_U; snk_ph = `SCC_PH_W; end
      3'h5: begin src_ph = `SCC_PH_U; snk_ph = `SCC_PH_V; end
      default: begin src_ph = `SCC_PH_NONE; snk_ph = `SCC_PH_NONE; end
    endcase
  end
  wire is_rev = (mode_q == MODE_REVERSE);
  wire [2:0] src_leg = scc_onehot(is_rev ? snk_ph : src_ph);
  wire [2:0] snk_leg = scc_onehot(is_rev ? src_ph : snk_ph);
  wire rev_halt_set = is_rev && cif.hall_rev;
  wire stopped = (mode_d == MODE_STANDBY) || (mode_d == MODE_STARTUP);

  // Carrier: triangle counter, frozen at zero in standby to save power
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tri_q <= '0;
      tri_up_q <= 1'b1;
    end else if (!standby_n_in) begin
      tri_q <= '0;
      tri_up_q <= 1'b1;
    end else if (tri_up_q) begin
      tri_q <= TRI_W'(tri_q + 1'b1);
      tri_up_q <= (tri_q != TRI_PEAK - 1'b1);
    end else begin
      tri_q <= TRI_W'(tri_q - 1'b1);
      tri_up_q <= (tri_q == 1);
    end
  end

  // Duty is taken only at the valley, so one carrier period never
  // mixes two duty values; costs up to one period of command latency
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      duty_q <= '0;
      pwm_on_q <= 1'b0;
    end else begin
      if (tri_q == '0) begin
        duty_q <= duty_calc;
      end
      pwm_on_q <= (tri_q < duty_q);
    end
  end

  // Start-up hold after standby release; reset also counts as a wake
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      startup_q <= SU_W'(STARTUP_CYC);
    end else if (!standby_n_in) begin
      startup_q <= SU_W'(STARTUP_CYC);
    end else if (startup_q != '0) begin
      startup_q <= startup_q - 1'b1;
    end
  end

  // Mode selection, highest priority first
  always_comb begin
    if (!standby_n_in) begin
      mode_d = MODE_STANDBY;
    end else if (startup_q != '0) begin
      mode_d = MODE_STARTUP;
    end else if (!run_stop_in) begin
      mode_d = MODE_STOP_BRAKE;
    end else if (hall_bad) begin
      mode_d = MODE_FAULT_OFF;
    end else if (fwd_req) begin
      mode_d = MODE_FORWARD;
    end else if (rev_req) begin
      mode_d = (rev_halt_q || rev_halt_set) ? MODE_REV_HALT :
               MODE_REVERSE;
    end else begin
      mode_d = MODE_SHORT_BRAKE;
    end
  end

  // Mode, halt latch and output enable registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= MODE_STARTUP;
      rev_halt_q <= 1'b0;
      out_en_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      rev_halt_q <= rev_req && (rev_halt_q || rev_halt_set);
      out_en_q <= !stopped;
    end
  end

  // Switch pattern per mode
  always_comb begin
    unique case (mode_q)
      MODE_STANDBY, MODE_STARTUP, MODE_FAULT_OFF, MODE_REV_HALT: begin
        cif.hs_cmd = `SCC_LEGS_OFF;
        cif.ls_cmd = `SCC_LEGS_OFF;
      end
      MODE_STOP_BRAKE, MODE_SHORT_BRAKE: begin
        cif.hs_cmd = `SCC_LEGS_ALL;
        cif.ls_cmd = `SCC_LEGS_OFF;
      end
      MODE_FORWARD, MODE_REVERSE: begin
        cif.hs_cmd = pwm_on_q ? src_leg : (src_leg | snk_leg);
        cif.ls_cmd = pwm_on_q ? snk_leg : `SCC_LEGS_OFF;
      end
    endcase
  end

  // Speed pulse: one phase, or the parity of all three for 3x rate
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      speed_q <= 1'b0;
    end else begin
      speed_q <= speed_pulse_select ? ^cif.hall_state :
                 cif.hall_state[2];
    end
  end

  assign phase_out_hs = cif.hs_on;
  assign phase_out_ls = cif.ls_on;
  assign phase_out_en = out_en_q;
  assign speed_pulse_out = speed_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_wake;
    $rose(standby_n_in);
  endsequence
  sequence s_run_ready;
    standby_n_in && startup_q == '0 && run_stop_in;
  endsequence

  property p_stop_brake;
    standby_n_in && startup_q == '0 && !run_stop_in |=>
      cif.hs_cmd == `SCC_LEGS_ALL && cif.ls_cmd == `SCC_LEGS_OFF;
  endproperty
  a_stop_brake: assert property (p_stop_brake)
    else $error("stop did not short brake");

  property p_standby_float;
    !standby_n_in |=> !phase_out_en;
  endproperty
  a_standby_float: assert property (p_standby_float)
    else $error("outputs enabled in standby");

  property p_wake_hold;
    s_wake |-> (!phase_out_en)[*8];
  endproperty
  a_wake_hold: assert property (p_wake_hold)
    else $error("drive enabled during start-up");

  property p_osc_halt;
    !standby_n_in |=> tri_q == '0;
  endproperty
  a_osc_halt: assert property (p_osc_halt)
    else $error("carrier runs in standby");

  property p_no_shoot;
    ((phase_out_hs & ~$past(phase_out_hs)) &
     ($past(phase_out_ls) | $past(phase_out_ls, 2))) == 3'h0 &&
    (phase_out_hs & phase_out_ls) == 3'h0;
  endproperty
  a_no_shoot: assert property (p_no_shoot)
    else $error("leg switched without dead time");

  property p_bad_hall;
    s_run_ready ##0 hall_bad |=>
      cif.hs_cmd == `SCC_LEGS_OFF && cif.ls_cmd == `SCC_LEGS_OFF;
  endproperty
  a_bad_hall: assert property (p_bad_hall)
    else $error("illegal hall state not turned off");

  property p_rev_stop;
    is_rev && cif.hall_rev |=> mode_q != MODE_REVERSE;
  endproperty
  a_rev_stop: assert property (p_rev_stop)
    else $error("reverse drive kept after backward step");

  property p_pwm_on;
    mode_q == MODE_FORWARD && !hall_bad && pwm_on_q |->
      $onehot(cif.ls_cmd) && $onehot(cif.hs_cmd);
  endproperty
  a_pwm_on: assert property (p_pwm_on)
    else $error("excited step without one low side");

  property p_pwm_off;
    mode_q == MODE_FORWARD && !hall_bad && !pwm_on_q |->
      cif.ls_cmd == `SCC_LEGS_OFF && $countones(cif.hs_cmd) == 2;
  endproperty
  a_pwm_off: assert property (p_pwm_off)
    else $error("regeneration not through high sides");

  property p_speed_single;
    !speed_pulse_select |=> speed_pulse_out == $past(cif.hall_state[2]);
  endproperty
  a_speed_single: assert property (p_speed_single)
    else $error("single-phase speed pulse wrong");

  property p_speed_three;
    speed_pulse_select |=> speed_pulse_out == ^$past(cif.hall_state);
  endproperty
  a_speed_three: assert property (p_speed_three)
    else $error("three-phase speed pulse wrong");

endmodule : scc_spindle_ctrl

// file: rtl/scc_params.svh
// Constants of the spindle commutation controller: timing, codes, levels.
// Assumes a 100 MHz system clock and torque inputs coded in millivolts.
`ifndef SCC_PARAMS_SVH
`define SCC_PARAMS_SVH

`define SCC_CLK_NS 10
`define SCC_PWM_FREQ_HZ 75000
`define SCC_PWM_CYC (1000000000 / (`SCC_PWM_FREQ_HZ * `SCC_CLK_NS))
`define SCC_TRI_PEAK (`SCC_PWM_CYC / 2)
`define SCC_DEADBAND_MV 50
`define SCC_FULL_DUTY_MV 750
`define SCC_STARTUP_US 30
`define SCC_STARTUP_CYC ((`SCC_STARTUP_US * 1000) / `SCC_CLK_NS)
`define SCC_DEAD_NS 200
`define SCC_DEAD_CYC ((`SCC_DEAD_NS + `SCC_CLK_NS - 1) / `SCC_CLK_NS)

// Hall states {a,b,c} in forward step order
`define SCC_HALL_S0 3'h6
`define SCC_HALL_S1 3'h4
`define SCC_HALL_S2 3'h5
`define SCC_HALL_S3 3'h1
`define SCC_HALL_S4 3'h3
`define SCC_HALL_S5 3'h2
`define SCC_STEP_LAST 3'h5
`define SCC_STEP_FIRST 3'h0
`define SCC_STEP_NONE 3'h7

// Phase indices and leg patterns
`define SCC_PH_U 2'h0
`define SCC_PH_V 2'h1
`define SCC_PH_W 2'h2
`define SCC_PH_NONE 2'h3
`define SCC_LEGS_OFF 3'h0
`define SCC_LEGS_ALL 3'h7

`endif

// file: rtl/scc_pkg.sv
// Types and shared decoders of the spindle commutation controller.
// Assumes scc_params.svh is on the include path.
`include "scc_params.svh"

package scc_pkg;

  typedef enum logic [2:0] {
    MODE_STANDBY,
    MODE_STARTUP,
    MODE_STOP_BRAKE,
    MODE_FAULT_OFF,
    MODE_FORWARD,
    MODE_SHORT_BRAKE,
    MODE_REVERSE,
    MODE_REV_HALT
  } scc_mode_t;

  typedef logic [2:0] scc_leg_t;

  // Hall state to commutation step, none for illegal states
  function automatic logic [2:0] scc_step_of(input logic [2:0] h);
    logic [2:0] s;
    s = `SCC_STEP_NONE;
    case (h)
      `SCC_HALL_S0: s = 3'h0;
      `SCC_HALL_S1: s = 3'h1;
      `SCC_HALL_S2: s = 3'h2;
      `SCC_HALL_S3: s = 3'h3;
      `SCC_HALL_S4: s = 3'h4;
      `SCC_HALL_S5: s = 3'h5;
      default: s = `SCC_STEP_NONE;
    endcase
    return s;
  endfunction : scc_step_of

  // Phase index to one-hot leg pattern, none gives no leg
  function automatic scc_leg_t scc_onehot(input logic [1:0] ph);
    scc_leg_t l;
    l = `SCC_LEGS_OFF;
    if (ph != `SCC_PH_NONE) begin
      l[ph] = 1'b1;
    end
    return l;
  endfunction : scc_onehot

endpackage : scc_pkg

// file: rtl/scc_core_if.sv
// Carrier between the controller core, Hall front end and leg drivers.
// Assumes all three sit on the same clock.
`timescale 1ns/100ps

interface scc_core_if;
  import scc_pkg::*;
  logic [2:0] hall_state;
  logic hall_fwd;
  logic hall_rev;
  scc_leg_t hs_cmd;
  scc_leg_t ls_cmd;
  scc_leg_t hs_on;
  scc_leg_t ls_on;
  modport sync (output hall_state, output hall_fwd, output hall_rev);
  modport dt (input hs_cmd, input ls_cmd, output hs_on, output ls_on);
  modport core (input hall_state, input hall_fwd, input hall_rev,
                input hs_on, input ls_on,
                output hs_cmd, output ls_cmd);
endinterface : scc_core_if

// file: rtl/scc_hall_sync.sv
// Hall comparator front end: synchroniser, state register, step direction.
// Assumes the comparator outputs are asynchronous to clk.
`timescale 1ns/100ps
`include "scc_params.svh"

module scc_hall_sync
  import scc_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic hall_a_pos, // Hall comparator a
  input wire logic hall_b_pos, // Hall comparator b
  input wire logic hall_c_pos, // Hall comparator c
  scc_core_if.sync cif // Hall state and step pulses
);

  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic [2:0] state_q;
  logic fwd_q;
  logic rev_q;

  // Step indices of the new and the held state
  wire [2:0] idx_new = scc_step_of(sync_q);
  wire [2:0] idx_old = scc_step_of(state_q);
  wire both_ok = (idx_new != `SCC_STEP_NONE) && (idx_old != `SCC_STEP_NONE);
  wire [2:0] idx_next = (idx_old == `SCC_STEP_LAST) ? `SCC_STEP_FIRST :
                        3'(idx_old + 3'h1);
  wire [2:0] idx_prev = (idx_old == `SCC_STEP_FIRST) ? `SCC_STEP_LAST :
                        3'(idx_old - 3'h1);
  wire moved = both_ok && (sync_q != state_q);

  // Two flops before anything decodes, so a slow edge never glitches
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= 3'h0;
      sync_q <= 3'h0;
    end else begin
      meta_q <= {hall_a_pos, hall_b_pos, hall_c_pos};
      sync_q <= meta_q;
    end
  end

  // Held state and one-cycle direction pulses
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= 3'h0;
      fwd_q <= 1'b0;
      rev_q <= 1'b0;
    end else begin
      state_q <= sync_q;
      fwd_q <= moved && (idx_new == idx_next);
      rev_q <= moved && (idx_new == idx_prev);
    end
  end

  assign cif.hall_state = state_q;
  assign cif.hall_fwd = fwd_q;
  assign cif.hall_rev = rev_q;

endmodule : scc_hall_sync

// file: rtl/scc_dead_time.sv
// Per-leg dead-time insertion between high-side and low-side switches.
// Assumes the core never asks for both switches of one leg at once.
`timescale 1ns/100ps
`include "scc_params.svh"

module scc_dead_time
  import scc_pkg::*;
#(
  parameter int DEAD_CYC = `SCC_DEAD_CYC
) (
  input wire logic clk, // System clock
  input wire logic resetn, // Asynchronous reset, active low
  scc_core_if.dt cif // Requested and applied switch states
);

  localparam int CW = $clog2(DEAD_CYC + 1);

  generate
    if (DEAD_CYC < 1 || DEAD_CYC > 255) begin : g_bad
      $error("scc_dead_time: DEAD_CYC out of range");
    end
  endgenerate

  // One leg per iteration: break first, wait, then make
  for (genvar i = 0; i < 3; i++) begin : g_leg
    logic hs_q;
    logic ls_q;
    logic [CW-1:0] cnt_q;
    wire same = (cif.hs_cmd[i] == hs_q) && (cif.ls_cmd[i] == ls_q);
    wire idle = !hs_q && !ls_q;

    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        hs_q <= 1'b0;
        ls_q <= 1'b0;
        cnt_q <= '0;
      end else if (!idle && !same) begin
        hs_q <= 1'b0;
        ls_q <= 1'b0;
        cnt_q <= CW'(DEAD_CYC);
      end else if (idle && cnt_q != '0) begin
        cnt_q <= cnt_q - 1'b1;
      end else if (idle) begin
        hs_q <= cif.hs_cmd[i];
        ls_q <= cif.ls_cmd[i];
      end
    end

    assign cif.hs_on[i] = hs_q;
    assign cif.ls_on[i] = ls_q;
  end

endmodule : scc_dead_time

// file: bench/scc_motor_model.sv
// Far-side model: Hall comparators of a three-phase spindle motor.
// Assumes the bench names the rotor position by its Hall code.
`timescale 1ns/100ps

module scc_motor_model (
  input wire logic [2:0] hall_target, // Hall code {a,b,c} to present
  output logic hall_a_pos, // Comparator a
  output logic hall_b_pos, // Comparator b
  output logic hall_c_pos // Comparator c
);
  // Comparator edges land 3 ns after the bench edge, off the clock grid,
  // so the design's synchroniser sees truly asynchronous transitions;
  // a continuous assign also carries the value set at time zero
  assign #3 {hall_a_pos, hall_b_pos, hall_c_pos} = hall_target;
endmodule : scc_motor_model

// file: bench/scc_spindle_ctrl_tb.sv
// Self-checking bench of the spindle commutation controller.
// Assumes a 100 MHz clock; shortened start-up and dead-time counts.
`timescale 1ns/100ps

module scc_spindle_ctrl_tb;
  import scc_pkg::*;
  localparam int SU = 20;
  localparam int DT = 2;
  // Forward step order and the excited pair of each step, bit 0 is U
  localparam logic [2:0] CODE [6] = '{3'h6, 3'h4, 3'h5, 3'h1, 3'h3, 3'h2};
  localparam logic [2:0] SRC [6] = '{3'h4, 3'h4, 3'h2, 3'h2, 3'h1, 3'h1};
  localparam logic [2:0] SNK [6] = '{3'h2, 3'h1, 3'h1, 3'h4, 3'h4, 3'h2};

  logic clk, resetn, run_stop_in, standby_n_in;
  logic brake_style_select, speed_pulse_select;
  logic [11:0] torque_reference, torque_command;
  logic [2:0] hall_target;
  logic hall_a, hall_b, hall_c;
  logic [2:0] phase_out_hs, phase_out_ls;
  logic phase_out_en, speed_pulse_out;
  logic [7:0] pat;
  logic overlap_q;
  int n_mismatch, tests_run, cnt, k;

  scc_spindle_ctrl #(.CODE_W(12), .STARTUP_CYC(SU), .DEAD_CYC(DT)) uut (
    .clk(clk),
    .resetn(resetn),
    .run_stop_in(run_stop_in),
    .standby_n_in(standby_n_in),
    .brake_style_select(brake_style_select),
    .speed_pulse_select(speed_pulse_select),
    .hall_a_pos(hall_a),
    .hall_b_pos(hall_b),
    .hall_c_pos(hall_c),
    .torque_reference(torque_reference),
    .torque_command(torque_command),
    .phase_out_hs(phase_out_hs),
    .phase_out_ls(phase_out_ls),
    .phase_out_en(phase_out_en),
    .speed_pulse_out(speed_pulse_out)
  );

  scc_motor_model motor (
    .hall_target(hall_target),
    .hall_a_pos(hall_a),
    .hall_b_pos(hall_b),
    .hall_c_pos(hall_c)
  );

  // Enable, then both switch banks, in one word for compact compares
  assign pat = {phase_out_en, 1'b0, phase_out_hs, phase_out_ls};

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // A leg shorted through both switches is latched for the final compare
  always @(posedge clk) begin
    if (!resetn) begin
      overlap_q <= 1'b0;
    end else if ((phase_out_hs & phase_out_ls) !== 3'h0) begin
      overlap_q <= 1'b1;
    end
  end

  function automatic logic [7:0] ep(input logic [2:0] hs,
                                    input logic [2:0] ls);
    return {2'b10, hs, ls};
  endfunction : ep

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // Rotor move; 20 cycles covers sync, decode and dead time
  task automatic hall(input logic [2:0] t);
    @(posedge clk);
    hall_target <= t;
    cyc(20);
  endtask : hall

  // New torque inputs; duty is latched once per 1332-cycle carrier
  task automatic torque(input int r, input int c);
    @(posedge clk);
    torque_reference <= 12'(r);
    torque_command <= 12'(c);
    cyc(1400);
  endtask : torque

  task automatic wait_en(input logic v);
    int i;
    for (i = 0; i < 200 && phase_out_en !== v; i++) @(posedge clk);
    if (phase_out_en !== v) begin
      n_mismatch++;
      $display("ERROR t=%0t enable wait ran out", $time);
      test_done();
    end
  endtask : wait_en

  task automatic test_done;
    $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  // Hang guard, far above the planned run length
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    $display("ERROR t=%0t run did not finish", $time);
    test_done();
  end

  initial begin
    resetn = 1'b0;
    run_stop_in = 1'b1;
    standby_n_in = 1'b1;
    brake_style_select = 1'b0;
    speed_pulse_select = 1'b0;
    torque_reference = 12'h3E8;
    torque_command = 12'h064;
    hall_target = 3'h6;
    n_mismatch = 0;
    tests_run = 0;
    cyc(12);
    resetn <= 1'b1;
    cyc(10);
    chk({7'h0, phase_out_en}, 8'h00);
    wait_en(1'b1);
    // Full duty forward through every step of the table
    torque(1000, 100);
    for (k = 0; k < 6; k++) begin
      hall(CODE[k]);
      chk(pat, ep(SRC[k], SNK[k]));
    end
    // Inside the deadband: PWM off, current recirculates high side
    torque(1000, 950);
    chk(pat, ep(SRC[5] | SNK[5], 3'h0));
    // Half duty: 375 mV past the deadband is 50% of the 1332-cycle
    // triangle (both slopes), less about 3 cycles of dead time
    torque(1000, 575);
    cnt = 0;
    repeat (1333) begin
      @(posedge clk);
      if (phase_out_ls !== 3'h0) cnt++;
    end
    chk({7'h0, cnt >= 655 && cnt <= 670}, 8'h01);
    // Stop: all high sides on regardless of Hall or PWM
    @(posedge clk);
    run_stop_in <= 1'b0;
    cyc(20);
    chk(pat, ep(3'h7, 3'h0));
    @(posedge clk);
    run_stop_in <= 1'b1;
    // Illegal Hall codes switch everything off
    hall(3'h0);
    chk(pat, ep(3'h0, 3'h0));
    hall(3'h7);
    chk(pat, ep(3'h0, 3'h0));
    hall(CODE[0]);
    // Short brake at equal inputs and with command above reference
    torque(1000, 1000);
    chk(pat, ep(3'h7, 3'h0));
    torque(1000, 1500);
    chk(pat, ep(3'h7, 3'h0));
    // Reverse brake swaps source and sink while still turning forward
    @(posedge clk);
    brake_style_select <= 1'b1;
    torque(1000, 1900);
    chk(pat, ep(SNK[0], SRC[0]));
    hall(CODE[1]);
    chk(pat, ep(SNK[1], SRC[1]));
    // A backward step means the rotor reversed: drive must stop
    hall(CODE[0]);
    chk(pat, ep(3'h0, 3'h0));
    hall(CODE[5]);
    chk(pat, ep(3'h0, 3'h0));
    @(posedge clk);
    brake_style_select <= 1'b0;
    cyc(20);
    chk(pat, ep(3'h7, 3'h0));
    // Speed pulse sources: Hall a alone, then all three combined
    for (k = 0; k < 6; k++) begin
      hall(CODE[k]);
      chk({7'h0, speed_pulse_out}, {7'h0, CODE[k][2]});
    end
    @(posedge clk);
    speed_pulse_select <= 1'b1;
    for (k = 0; k < 6; k++) begin
      hall(CODE[k]);
      chk({7'h0, speed_pulse_out}, {7'h0, ^CODE[k]});
    end
    // Hall a falls 110 -> 010; two edges on, the pulse has not moved yet
    @(posedge clk);
    speed_pulse_select <= 1'b0;
    hall(CODE[0]);
    @(posedge clk);
    hall_target <= CODE[5];
    cyc(2);
    chk({7'h0, speed_pulse_out}, 8'h01);
    cyc(20);
    chk({7'h0, speed_pulse_out}, 8'h00);
    // Standby floats the outputs and ignores run/stop
    @(posedge clk);
    standby_n_in <= 1'b0;
    run_stop_in <= 1'b0;
    cyc(3);
    chk(pat, 8'h00);
    cyc(20);
    chk(pat, 8'h00);
    @(posedge clk);
    standby_n_in <= 1'b1;
    cyc(10);
    chk({7'h0, phase_out_en}, 8'h00);
    wait_en(1'b1);
    cyc(10);
    chk(pat, ep(3'h7, 3'h0));
    chk({7'h0, overlap_q}, 8'h00);
    test_done();
  end
endmodule : scc_spindle_ctrl_tb
